//--- dv/adc_two_wire_read_slave_test.sv
`timescale 1ns/1ps
`default_nettype none

module adc_two_wire_read_slave_test
  import adc_link_pkg::*;
();

  localparam logic [2:0] PREFIX = 3'h6; // Arbitrary value

  logic        i_core_clk;
  logic        i_conv_osc_clk;
  logic        i_rst_b;
  logic [3:0]  pins;
  logic        ext_ref;
  logic [15:0] sample;
  logic        scl_oe;
  logic        sda_oe;
  logic        scl_out;
  logic        sda_out;
  logic        hs;
  power_ctl_t  power;
  logic        m_scl_low;
  logic        m_sda_low;
  logic        m_timeout;
  wire logic   scl_w;
  wire logic   sda_w;
  int          n_mismatch;
  int          n_checks;

  // Pull-ups: a line is high unless some party pulls it low
  assign scl_w = ~(m_scl_low | (scl_oe & ~scl_out));
  assign sda_w = ~(m_sda_low | (sda_oe & ~sda_out));

  // Oscillator phase offset keeps the two domains unrelated
  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial
  begin
    i_conv_osc_clk = 1'b0;
    #3.3;
    forever #7.5 i_conv_osc_clk = ~i_conv_osc_clk;
  end

  adc_two_wire_read_slave #(.FACTORY_PREFIX(PREFIX)) dut (
    .i_core_clk                       (i_core_clk),
    .i_conv_osc_clk                   (i_conv_osc_clk),
    .i_rst_b                          (i_rst_b),
    .i_scl                            (scl_w),
    .i_sda                            (sda_w),
    .i_address_select_pins            (pins),
    .i_reference_adjust_pin_at_supply (ext_ref),
    .i_analog_sample                  (sample),
    .o_scl_out                        (scl_out),
    .o_scl_oe                         (scl_oe),
    .o_sda_out                        (sda_out),
    .o_sda_oe                         (sda_oe),
    .o_high_speed_timing              (hs),
    .o_power                          (power)
  );

  two_wire_master_model u_master (
    .i_clk     (i_core_clk),
    .i_scl     (scl_w),
    .i_sda     (sda_w),
    .o_scl_low (m_scl_low),
    .o_sda_low (m_sda_low),
    .o_timeout (m_timeout)
  );

  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A stuck stretch ends the run rather than hanging it
  always @(posedge m_timeout)
  begin
    n_mismatch++;
    $display("Error scl release expected 1 seen 0");
    give_verdict();
  end

  ////////////////////////////////////////////////////////////
  // Address, stretch, both result bytes; last byte not acknowledged
  task automatic read_body(input logic rw, input logic [15:0] val);
    logic       a;
    logic [7:0] hi;
    logic [7:0] lo;
    u_master.send_byte({PREFIX, pins, rw}, a);
    chk_bit("address ack", 1'b0, a);
    u_master.wait_cyc(6);
    chk_bit("scl stretch", 1'b1, scl_oe);
    chk_bit("adc power", 1'b1, power.adc_on);
    chk_bit("ref wake", ~ext_ref, power.ref_on);
    chk_bit("track in conv", 1'b0, power.track);
    u_master.recv_byte(1'b1, hi);
    u_master.recv_byte(1'b0, lo);
    chk_word("result", val, {hi, lo});
    u_master.wait_cyc(6);
    chk_bit("adc off", 1'b0, power.adc_on);
    chk_bit("ref after nack", ~ext_ref & rw, power.ref_on);
    chk_bit("sda released", 1'b0, sda_oe);
  endtask

  task automatic t_reset_state();
    chk_bit("adc power", 1'b0, power.adc_on);
    chk_bit("ref power", 1'b0, power.ref_on);
    chk_bit("high_speed_timing", 1'b0, hs);
    chk_bit("stretch", 1'b0, scl_oe);
    chk_bit("scl drive level", 1'b0, scl_out);
    chk_bit("sda drive level", 1'b0, sda_out);
  endtask

  // Every reference and power-down mode, straps at both ends
  task automatic t_modes();
    logic [21:0] tbl [4];
    tbl = '{{1'b1, 1'b0, 4'h9, 16'hA55A}, {1'b0, 1'b0, 4'h0, 16'h8001},
            {1'b0, 1'b1, 4'hF, 16'hFFFE}, {1'b1, 1'b1, 4'h6, 16'h0000}};
    for (int i = 0; i < 4; i++)
    begin
      ext_ref <= tbl[i][20];
      pins    <= tbl[i][19:16];
      sample  <= tbl[i][15:0];
      u_master.wait_cyc(4);
      u_master.start();
      read_body(tbl[i][21], tbl[i][15:0]);
      u_master.stop();
    end
  endtask

  // Foreign address ignored; the master then retries correctly
  task automatic t_refuse_retry();
    logic a;
    u_master.start();
    u_master.send_byte({~PREFIX, pins, 1'b1}, a);
    chk_bit("foreign ack", 1'b1, a);
    u_master.wait_cyc(6);
    chk_bit("foreign power", 1'b0, power.adc_on);
    u_master.stop();
    u_master.start();
    read_body(1'b1, sample);
    u_master.stop();
  endtask

  // Acknowledged low byte converts again; held result ignores input moves
  task automatic t_continuous();
    logic [7:0] hi;
    logic [7:0] lo;
    logic       a;
    sample <= 16'h1234;
    u_master.wait_cyc(4);
    u_master.start();
    u_master.send_byte({PREFIX, pins, 1'b1}, a);
    chk_bit("address ack", 1'b0, a);
    u_master.recv_byte(1'b1, hi);
    sample <= 16'hEDCB;
    u_master.recv_byte(1'b1, lo);
    chk_word("first result", 16'h1234, {hi, lo});
    u_master.wait_cyc(6);
    chk_bit("restretch", 1'b1, scl_oe);
    u_master.recv_byte(1'b1, hi);
    u_master.recv_byte(1'b0, lo);
    chk_word("second result", 16'hEDCB, {hi, lo});
    u_master.stop();
  endtask

  // Master code refused, high speed kept over Sr, dropped at STOP
  task automatic t_high_speed();
    logic [7:0] codes [2];
    logic       a;
    codes = '{8'h08, 8'h0F};
    for (int i = 0; i < 2; i++)
    begin
      u_master.start();
      u_master.send_byte(codes[i], a);
      chk_bit("code nack", 1'b1, a);
      u_master.wait_cyc(6);
      chk_bit("hs after code", 1'b1, hs);
      u_master.rstart();
      chk_bit("hs over sr", 1'b1, hs);
      read_body(1'b1, sample);
      u_master.stop();
      u_master.wait_cyc(6);
      chk_bit("hs after stop", 1'b0, hs);
    end
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    n_mismatch = 0;
    n_checks   = 0;
    i_rst_b    = 1'b0;
    pins       = 4'h9;
    ext_ref    = 1'b0;
    sample     = 16'h0000;
    repeat (20) @(posedge i_core_clk);
    t_reset_state();
    i_rst_b <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    t_reset_state();
    t_modes();
    t_refuse_retry();
    t_continuous();
    t_high_speed();
    give_verdict();
  end
endmodule

`default_nettype wire

//--- dv/two_wire_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module two_wire_master_model (
  input  wire logic i_clk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output var logic  o_scl_low,
  output var logic  o_sda_low,
  output var logic  o_timeout
);
  localparam int HALF        = 16;
  localparam int STRETCH_MAX = 1000;

  // Both lines released to their pull-ups until the first frame
  initial
  begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    o_timeout = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Release SCL; a slave may stretch, so wait for the wire, bounded
  task automatic scl_high();
    int k;
    k = 0;
    o_scl_low <= 1'b0;
    @(posedge i_clk);
    while (i_scl !== 1'b1 && k < STRETCH_MAX)
    begin
      @(posedge i_clk);
      k++;
    end
    if (k >= STRETCH_MAX)
      o_timeout <= 1'b1;
    wait_cyc(HALF);
  endtask

  // SDA moves mid low phase, sampled at the end of the high phase
  task automatic xfer_bit(input logic b, output logic r);
    wait_cyc(HALF / 2);
    o_sda_low <= ~b;
    wait_cyc(HALF / 2);
    scl_high();
    r = i_sda;
    o_scl_low <= 1'b1;
  endtask

  // START from idle: SDA falls while SCL is high
  task automatic start();
    o_sda_low <= 1'b1;
    wait_cyc(HALF);
    o_scl_low <= 1'b1;
  endtask

  // Repeated START from the low phase
  task automatic rstart();
    wait_cyc(HALF / 2);
    o_sda_low <= 1'b0;
    wait_cyc(HALF / 2);
    scl_high();
    start();
  endtask

  // STOP: SDA rises while SCL is high
  task automatic stop();
    wait_cyc(HALF / 2);
    o_sda_low <= 1'b1;
    wait_cyc(HALF / 2);
    scl_high();
    o_sda_low <= 1'b0;
    wait_cyc(HALF);
  endtask

  // Address or code byte MSB first, ninth clock left for the answer
  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer_bit(d[i], r);
    xfer_bit(1'b1, ack_n);
  endtask

  // Result byte; acknowledge low asks for more
  task automatic recv_byte(input logic give_ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(~give_ack, r);
  endtask
endmodule

`default_nettype wire

//--- rtl/adc_two_wire_read_slave.sv
// How it works
// - One bit per SCL clock, nine clocks per byte; SDA changes only while SCL low.
// - START is SDA falling with SCL high; STOP is SDA rising with SCL high.
// - STOP releases the bus and returns timing to fast/standard mode.
// - Repeated START keeps the bus active and keeps the current timing mode.
// - Acknowledge: receiver holds SDA low through the ninth clock high phase.
// - Not-acknowledge: receiver leaves SDA released through the ninth clock high phase.
// - Address byte is seven address bits then read/write bit as LSB.
// - Top three address bits fixed, low four bits from address select pins.
// - Idle slave watches for START plus matching address, then starts acquiring.
// - Matching address byte is acknowledged by SDA low for one clock.
// - Read/write bit ignored with reference tied off; 0 requests reference power-down.
// - Bus timing starts in fast/standard mode after power-up.
// - Master code 0000_1xxx gets a not-acknowledge, then high-speed timing starts.
// - After address acknowledge, SCL is held low until conversion completes.
// - Result shifted out high byte (bits 15..8) then low byte (7..0).
// - Master acknowledge keeps converting; master not-acknowledge releases the bus.
// - Power-on reset leaves converter and reference shut down.
// - Interface always active; converter powers up on valid address, down when done.
// - Internal reference with read/write 0 shuts off on result not-acknowledge.
// - Internal reference starts waking on ninth falling SCL of a valid address.
// - Track during the two SCL cycles before conversion, hold otherwise.
// - Conversion runs on its own oscillator, independent of SCL.
`timescale 1ns/1ps
`default_nettype none
`include "adc_link_regs.svh"

module adc_two_wire_read_slave
  import adc_link_pkg::*;
#(
  parameter logic [`ADDR_PREFIX_W-1:0] FACTORY_PREFIX = 3'h5 // Arbitrary value
)(
  input  wire logic                    i_core_clk,
  input  wire logic                    i_conv_osc_clk,
  input  wire logic                    i_rst_b,
  input  wire logic                    i_scl,
  input  wire logic                    i_sda,
  input  wire logic [`ADDR_PIN_W-1:0]  i_address_select_pins,
  input  wire logic                    i_reference_adjust_pin_at_supply,
  input  wire logic [`RESULT_W-1:0]    i_analog_sample,
  output logic                         o_scl_out,
  output logic                         o_scl_oe,
  output logic                         o_sda_out,
  output logic                         o_sda_oe,
  output logic                         o_high_speed_timing,
  output power_ctl_t                   o_power
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release, one synchroniser per domain

  logic        rst_core_m_ff;
  logic        rst_core_b;
  logic        rst_osc_m_ff;
  logic        rst_osc_b;

  // Assert at once, release two edges later in each domain
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_core_m_ff <= 1'b0;
      rst_core_b    <= 1'b0;
    end
    else
    begin
      rst_core_m_ff <= 1'b1;
      rst_core_b    <= rst_core_m_ff;
    end
  end

  always_ff @(posedge i_conv_osc_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_osc_m_ff <= 1'b0;
      rst_osc_b    <= 1'b0;
    end
    else
    begin
      rst_osc_m_ff <= 1'b1;
      rst_osc_b    <= rst_osc_m_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding

  // Seven received bits against prefix and strapped pins
  function automatic logic addr_match(input logic [6:0] a, input logic [`ADDR_PIN_W-1:0] pins);
    addr_match = (a == {FACTORY_PREFIX, pins});
  endfunction

  // High-speed master code, low three bits ignored
  function automatic logic is_mcode(input logic [7:0] b);
    is_mcode = (b[7:3] == `MCODE_TOP);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Core domain state

  core_state_t st_ff;
  core_state_t nxt_st;
  osc_state_t  os_ff;
  osc_state_t  nxt_os;

  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        done_evt;
  logic        go_conv;

  // Edges on the synchronised copies only, never the first flop
  assign scl_rise  = st_ff.scl_s & ~st_ff.scl_p;
  assign scl_fall  = ~st_ff.scl_s & st_ff.scl_p;
  assign start_det = st_ff.scl_s & st_ff.scl_p & st_ff.sda_p & ~st_ff.sda_s;
  assign stop_det  = st_ff.scl_s & st_ff.scl_p & ~st_ff.sda_p & st_ff.sda_s;
  assign done_evt  = st_ff.done_s ^ st_ff.done_p;

  // Bus protocol and conversion control
  always_comb
  begin
    nxt_st          = st_ff;
    go_conv         = 1'b0;
    nxt_st.scl_m    = i_scl;
    nxt_st.scl_s    = st_ff.scl_m;
    nxt_st.scl_p    = st_ff.scl_s;
    nxt_st.sda_m    = i_sda;
    nxt_st.sda_s    = st_ff.sda_m;
    nxt_st.sda_p    = st_ff.sda_s;
    nxt_st.apin_m   = i_address_select_pins;
    nxt_st.apin_s   = st_ff.apin_m;
    nxt_st.refsup_m = i_reference_adjust_pin_at_supply;
    nxt_st.refsup_s = st_ff.refsup_m;
    nxt_st.smp_m    = i_analog_sample;
    nxt_st.smp_s    = st_ff.smp_m;
    nxt_st.done_m   = os_ff.done_tgl;
    nxt_st.done_s   = st_ff.done_m;
    nxt_st.done_p   = st_ff.done_s;
    // Converter sleeps as soon as a result is in
    if (done_evt)
      nxt_st.pwr.adc_on = 1'b0;
    if (stop_det)
    begin
      nxt_st.fsm       = ph_idle;
      nxt_st.sda_oe    = 1'b0;
      nxt_st.scl_oe    = 1'b0;
      nxt_st.hs        = 1'b0;
      nxt_st.pwr.track = 1'b0;
    end
    else if (start_det)
    begin
      // Repeated START leaves timing mode untouched
      nxt_st.fsm       = ph_addr;
      nxt_st.cnt       = `CNT_CLEAR;
      nxt_st.sda_oe    = 1'b0;
      nxt_st.pwr.track = 1'b0;
    end
    else
    begin
      unique case (st_ff.fsm)
        ph_idle, ph_wait:
        begin
          nxt_st.fsm = st_ff.fsm; // Only START or STOP leave here
        end
        ph_addr:
        begin
          if (scl_rise)
            nxt_st.sh = {st_ff.sh[6:0], st_ff.sda_s};
          if (scl_fall)
          begin
            nxt_st.cnt = st_ff.cnt + `CNT_STEP;
            // Track for R/W and ack clocks once the address is known
            if (st_ff.cnt == `ADDR_TRACK_FALL && addr_match(st_ff.sh[6:0], st_ff.apin_s))
              nxt_st.pwr.track = 1'b1;
            if (st_ff.cnt == `ADDR_ACK_FALL)
            begin
              nxt_st.matched = addr_match(st_ff.sh[7:1], st_ff.apin_s);
              nxt_st.rw      = st_ff.sh[0];
              nxt_st.sda_oe  = addr_match(st_ff.sh[7:1], st_ff.apin_s);
              if (addr_match(st_ff.sh[7:1], st_ff.apin_s) || is_mcode(st_ff.sh))
                nxt_st.fsm = ph_ack; // Master code: SDA left released
              else
                nxt_st.fsm = ph_wait;
            end
          end
        end
        ph_ack:
        begin
          // Ninth falling edge ends the acknowledge clock
          if (scl_fall)
          begin
            nxt_st.sda_oe = 1'b0;
            nxt_st.cnt    = `CNT_CLEAR;
            if (st_ff.matched)
            begin
              go_conv = 1'b1;
              if (!st_ff.refsup_s)
                nxt_st.pwr.ref_on = 1'b1;
            end
            else
            begin
              nxt_st.hs  = 1'b1;
              nxt_st.fsm = ph_wait;
            end
          end
        end
        ph_conv:
        begin
          // Result latched; first bit driven in the same cycle that SCL is released
          if (done_evt)
          begin
            nxt_st.hold_res = os_ff.result;
            nxt_st.out_sh   = os_ff.result;
            nxt_st.sda_oe   = ~os_ff.result[`RESULT_MSB];
            nxt_st.scl_oe   = 1'b0;
            nxt_st.cnt      = `CNT_CLEAR;
            nxt_st.byte_sel = 1'b0;
            nxt_st.fsm      = ph_send;
          end
        end
        ph_send:
        begin
          if (scl_fall)
          begin
            nxt_st.cnt = st_ff.cnt + `CNT_STEP;
            if (st_ff.byte_sel && st_ff.cnt == `FALL_ADDR_DONE)
              nxt_st.pwr.track = 1'b1;
            if (st_ff.cnt == `FALL_BYTE_DONE)
            begin
              nxt_st.sda_oe = 1'b0; // Release for master acknowledge
              nxt_st.fsm    = ph_mack;
            end
            else
            begin
              nxt_st.out_sh = {st_ff.out_sh[`RESULT_NEXT:0], 1'b0};
              nxt_st.sda_oe = ~st_ff.out_sh[`RESULT_NEXT];
            end
          end
        end
        ph_mack:
        begin
          if (scl_rise)
            nxt_st.mack = ~st_ff.sda_s;
          if (scl_fall)
          begin
            nxt_st.cnt = `CNT_CLEAR;
            if (st_ff.mack && !st_ff.byte_sel)
            begin
              nxt_st.byte_sel = 1'b1;
              nxt_st.out_sh   = {st_ff.out_sh[`RESULT_NEXT:0], 1'b0};
              nxt_st.sda_oe   = ~st_ff.out_sh[`RESULT_NEXT];
              nxt_st.fsm      = ph_send;
            end
            else if (st_ff.mack)
              go_conv = 1'b1;
            else
            begin
              // Bus freed for STOP or repeated START
              nxt_st.pwr.track = 1'b0;
              nxt_st.fsm       = ph_wait;
              if (!st_ff.rw && !st_ff.refsup_s)
                nxt_st.pwr.ref_on = 1'b0;
            end
          end
        end
        default:
        begin
          nxt_st.fsm = ph_idle;
        end
      endcase
    end
    // Conversion start: hold sample, stretch SCL, wake converter
    if (go_conv)
    begin
      nxt_st.pwr.track  = 1'b0;
      nxt_st.held       = st_ff.smp_s;
      nxt_st.req_tgl    = ~st_ff.req_tgl;
      nxt_st.scl_oe     = 1'b1;
      nxt_st.pwr.adc_on = 1'b1;
      nxt_st.fsm        = ph_conv;
    end
    // Tied-off reference never runs, whatever R/W said
    if (st_ff.refsup_s)
      nxt_st.pwr.ref_on = 1'b0;
  end

  // Reset gives fast/standard timing and full shutdown
  always_ff @(posedge i_core_clk or negedge rst_core_b)
  begin
    if (!rst_core_b)
    begin
      st_ff     <= '0;
      st_ff.fsm <= ph_idle;
      st_ff.scl_m <= 1'b1;
      st_ff.scl_s <= 1'b1;
      st_ff.scl_p <= 1'b1;
      st_ff.sda_m <= 1'b1;
      st_ff.sda_s <= 1'b1;
      st_ff.sda_p <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion oscillator domain: bit-serial SAR

  logic [`RESULT_W-1:0] sar_test;

  // Held word is stable from the request toggle until done returns
  always_comb
  begin
    nxt_os       = os_ff;
    sar_test     = os_ff.trial | (`SAR_ONE << os_ff.idx);
    nxt_os.req_m = st_ff.req_tgl;
    nxt_os.req_s = os_ff.req_m;
    if (!os_ff.busy && (os_ff.req_s != os_ff.req_seen))
    begin
      nxt_os.req_seen = os_ff.req_s;
      nxt_os.busy     = 1'b1;
      nxt_os.trial    = `RESULT_CLEAR;
      nxt_os.idx      = `SAR_TOP_IDX;
    end
    else if (os_ff.busy)
    begin
      if (sar_test <= st_ff.held)
        nxt_os.trial = sar_test;
      if (os_ff.idx == `SAR_LAST_IDX)
      begin
        nxt_os.result   = (sar_test <= st_ff.held) ? sar_test : os_ff.trial;
        nxt_os.busy     = 1'b0;
        nxt_os.done_tgl = ~os_ff.done_tgl;
      end
      else
        nxt_os.idx = os_ff.idx - `SAR_IDX_STEP;
    end
  end

  always_ff @(posedge i_conv_osc_clk or negedge rst_osc_b)
  begin
    if (!rst_osc_b)
      os_ff <= '0;
    else
      os_ff <= nxt_os;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins: open-drain, only ever pulled low

  assign o_scl_out           = 1'b0;
  assign o_scl_oe            = st_ff.scl_oe;
  assign o_sda_out           = 1'b0;
  assign o_sda_oe            = st_ff.sda_oe;
  assign o_high_speed_timing = st_ff.hs;
  assign o_power             = st_ff.pwr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_core_b);

  a_stop_release: assert property (stop_det |=> !st_ff.hs && !st_ff.sda_oe && !st_ff.scl_oe)
    else $error("STOP did not release bus or clear high-speed timing");
  a_rstart_keeps_mode: assert property (start_det |=> st_ff.hs == $past(st_ff.hs))
    else $error("Repeated START changed timing mode");
  a_addr_ack: assert property ((st_ff.fsm == ph_addr && scl_fall && st_ff.cnt == `ADDR_ACK_FALL
    && addr_match(st_ff.sh[7:1], st_ff.apin_s)) |=> st_ff.sda_oe && st_ff.fsm == ph_ack)
    else $error("Matching address not acknowledged");
  a_mcode_nack: assert property ((st_ff.fsm == ph_addr && scl_fall && st_ff.cnt == `ADDR_ACK_FALL
    && is_mcode(st_ff.sh)) |=> !st_ff.sda_oe ##1 (!st_ff.sda_oe && !st_ff.hs) [*1])
    else $error("Master code was acknowledged");
  a_hs_entry: assert property ((st_ff.fsm == ph_ack && !st_ff.matched && scl_fall) |=> st_ff.hs)
    else $error("High-speed timing not entered after master code");
  a_stretch_hold: assert property (st_ff.fsm == ph_conv |-> st_ff.scl_oe && st_ff.pwr.adc_on)
    else $error("SCL not held low during conversion");
  a_result_msb: assert property ((st_ff.fsm == ph_conv && done_evt && !stop_det && !start_det)
    |=> !st_ff.scl_oe && st_ff.sda_oe == ~st_ff.hold_res[`RESULT_MSB])
    else $error("Result MSB not presented on release");
  a_hold_stable: assert property ((st_ff.fsm == ph_send && $past(st_ff.fsm) == ph_send)
    |-> $stable(st_ff.hold_res))
    else $error("Result changed during shift-out");
  a_sda_scl_low: assert property (($changed(st_ff.sda_oe) && !$past(stop_det) && !$past(start_det))
    |-> !$past(st_ff.scl_s))
    else $error("SDA drive changed while SCL high");
  a_ref_shutdown: assert property ((st_ff.fsm == ph_mack && scl_fall && !st_ff.mack && !st_ff.rw
    && !stop_det) |=> !st_ff.pwr.ref_on && st_ff.fsm == ph_wait)
    else $error("Reference not shut down on not-acknowledge");
  a_power_off: assert property (done_evt |=> !st_ff.pwr.adc_on)
    else $error("Converter stayed powered after result");
  a_sar_length: assert property (@(posedge i_conv_osc_clk) disable iff (!rst_osc_b)
    $rose(os_ff.busy) |-> os_ff.busy [*8])
    else $error("Conversion ended early");

  c_hs_entry: cover property (st_ff.fsm == ph_ack && !st_ff.matched && scl_fall);
  c_conversion: cover property (st_ff.fsm == ph_conv && done_evt);
  c_second_byte: cover property (st_ff.fsm == ph_mack && scl_fall && st_ff.mack && st_ff.byte_sel);
  c_ref_off: cover property ($fell(st_ff.pwr.ref_on));

endmodule

`default_nettype wire

//--- shared/adc_link_pkg.sv
`default_nettype none
`include "adc_link_regs.svh"

package adc_link_pkg;

  // Bus-side phase of the slave
  typedef enum logic [2:0] {
    ph_idle,
    ph_addr,
    ph_ack,
    ph_conv,
    ph_send,
    ph_mack,
    ph_wait
  } phase_t;

  // Power and track/hold controls toward the analog section
  typedef struct packed {
    logic adc_on;
    logic ref_on;
    logic track;
  } power_ctl_t;

  // Core clock domain state
  typedef struct packed {
    logic                       scl_m;
    logic                       scl_s;
    logic                       scl_p;
    logic                       sda_m;
    logic                       sda_s;
    logic                       sda_p;
    logic [`ADDR_PIN_W-1:0]     apin_m;
    logic [`ADDR_PIN_W-1:0]     apin_s;
    logic                       refsup_m;
    logic                       refsup_s;
    logic [`RESULT_W-1:0]       smp_m;
    logic [`RESULT_W-1:0]       smp_s;
    logic                       done_m;
    logic                       done_s;
    logic                       done_p;
    phase_t                     fsm;
    logic [3:0]                 cnt;
    logic [7:0]                 sh;
    logic                       matched;
    logic                       rw;
    logic                       byte_sel;
    logic                       mack;
    logic [`RESULT_W-1:0]       hold_res;
    logic [`RESULT_W-1:0]       out_sh;
    logic [`RESULT_W-1:0]       held;
    logic                       req_tgl;
    logic                       sda_oe;
    logic                       scl_oe;
    logic                       hs;
    power_ctl_t                 pwr;
  } core_state_t;

  // Conversion oscillator domain state
  typedef struct packed {
    logic                       req_m;
    logic                       req_s;
    logic                       req_seen;
    logic                       busy;
    logic [3:0]                 idx;
    logic [`RESULT_W-1:0]       trial;
    logic [`RESULT_W-1:0]       result;
    logic                       done_tgl;
  } osc_state_t;

endpackage

`default_nettype wire

//--- shared/adc_link_regs.svh
`ifndef ADC_LINK_REGS_SVH
`define ADC_LINK_REGS_SVH

// Bit-count positions, counted in SCL falling edges before the current one
`define FALL_ADDR_DONE   4'h6
`define FALL_BYTE_DONE   4'h7
// Address phase also counts the SCL fall that closes START
`define ADDR_TRACK_FALL  4'h7
`define ADDR_ACK_FALL    4'h8
`define CNT_CLEAR        4'h0
`define CNT_STEP         4'h1

// Address byte layout
`define ADDR_PREFIX_W    3
`define ADDR_PIN_W       4
`define MCODE_TOP        5'h01

// Conversion result layout
`define RESULT_W         16
`define RESULT_MSB       15
`define RESULT_NEXT      14
`define SAR_TOP_IDX      4'hF
`define SAR_LAST_IDX     4'h0
`define SAR_IDX_STEP     4'h1
`define SAR_ONE          16'h0001
`define RESULT_CLEAR     16'h0000

`endif
